/* pkg/isa_xbus_params.svh */
`ifndef ISA_XBUS_PARAMS_SVH
`define ISA_XBUS_PARAMS_SVH

// ****************************************
// fixed i/o ports
// ****************************************
`define KBD_DATA_PORT 16'h0060
`define KBD_CMD_PORT 16'h0064
`define MICRO_DATA_PORT 16'h0062
`define MICRO_CMD_PORT 16'h0066
`define RTC_INDEX_PORT 16'h0070
`define RTC_DATA_PORT 16'h0071

// ****************************************
// firmware window, la[23:20] of low and top alias
// ****************************************
`define FW_LOW_ALIAS 4'h0
`define FW_TOP_ALIAS 4'hF
`define FW_SEG_BITS 3'h7

// ****************************************
// timing counts in isa clocks, init pulse count in system clocks
// ****************************************
`define RTC_ALE_CLKS 2'h2
`define ZWS_MEM16_CLKS 3'h2
`define ZWS_8BIT_CLKS 3'h3
`define STD_MEM16_CLKS 3'h3
`define STD_IO16_CLKS 3'h3
`define STD_8BIT_CLKS 3'h6
`define INIT_PULSE_CLKS 3'h4

`endif

/* pkg/isa_xbus_pkg.sv */
package isa_xbus_pkg;
    typedef enum logic {CYC_IDLE, CYC_RUN} cyc_state_e;
    typedef enum logic {DMA_IDLE, DMA_GRANT} dma_state_e;
    typedef logic [2:0] chan_t;
endpackage

/* src/isa_xbus_select_control.sv */
`timescale 1ns/1ps
`include "isa_xbus_params.svh"
// Overview of operation
// RULE1: standard memory write follows memory write below 1 Mbyte for dma/own/isa cycles
// RULE2: zero wait states shortens 16-bit memory to two clocks, 8-bit to three
// RULE3: zero wait states ignored for 16-bit i/o cycles, normal length kept
// RULE4: channel ready low with zero wait states: request ignored, ready governs
// RULE5: address-20 mask combines gate input with quick address-20 bit
// RULE6: firmware select from address for enabled ranges, never during dma
// RULE7: keyboard select for i/o access to ports 60h and 64h
// RULE8: microcontroller select for i/o access to ports 62h and 66h
// RULE9: programmable selects hit by pci-master i/o; transceiver enabled meanwhile
// RULE10: cpu reset request from keyboard controller makes an init pulse
// RULE11: write to 70h raises rtc latch from io write fall for two clocks
// RULE12: rtc select for i/o access to port 71h
// RULE13: direction low on every i/o read; memory only for firmware or apic (code: i/o reads in dma cycles lower it only via RULE16)
// RULE14: pci-master reads: direction low from read fall to rise, firmware or apic
// RULE15: isa-master reads: direction low from read fall to rise, firmware only
// RULE16: dma read from peripheral bus: direction low while acknowledge; else high
// RULE17: output enable only for decoded, enabled peripheral devices
// RULE18: output enable from command fall; ends at rise or address change
// RULE19: request and acknowledge polarity programmable; no acknowledge after dropped request
// RULE20: dma request edges treated as asynchronous
// RULE21: requester holds request until acknowledge is asserted
// RULE22: unused peripheral controls become software general-purpose outputs
// RULE23: each dma request passes a two-stage synchroniser before arbitration
module isa_xbus_select_control (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic isa_clk_i,
    input wire logic [19:0] sa_i,
    input wire logic [6:0] la_i,
    input wire logic memr_n_i,
    input wire logic memw_n_i,
    input wire logic ior_n_i,
    input wire logic iow_n_i,
    input wire logic dma_cycle_i,
    input wire logic pci_master_i,
    input wire logic isa_master_i,
    input wire logic io16_n_i,
    input wire logic mem16_n_i,
    input wire logic zerows_n_i,
    input wire logic iochrdy_i,
    input wire logic apic_hit_i,
    input wire logic gate_a20_in_i,
    input wire logic cpu_reset_req_n_i,
    input wire logic [7:0] dreq_i,
    input wire logic dma_done_i,
    input wire logic dma_xbus_read_i,
    input wire logic dreq_active_high_i,
    input wire logic dack_active_high_i,
    input wire logic quick_addr20_bit_i,
    input wire logic fw_low_en_i,
    input wire logic fw_high_en_i,
    input wire logic kbd_en_i,
    input wire logic micro_en_i,
    input wire logic rtc_en_i,
    input wire logic prog0_en_i,
    input wire logic prog1_en_i,
    input wire logic [15:0] prog0_base_i,
    input wire logic [7:0] prog0_mask_i,
    input wire logic [15:0] prog1_base_i,
    input wire logic [7:0] prog1_mask_i,
    input wire logic xbus_gpo_mode_i,
    input wire logic kbd_gpo_mode_i,
    input wire logic rtc_gpo_mode_i,
    input wire logic gp_out_dir_alt_i,
    input wire logic gp_out_oe_alt_i,
    input wire logic gp_out_rtcsel_alt_i,
    input wire logic gp_out_rtc_addr_latch_alt_i,
    input wire logic gp_out_kbdsel_alt_i,
    output logic smemw_n_o,
    output logic cycle_end_o,
    output logic addr20_mask_n_o,
    output logic firmware_sel_n_o,
    output logic kbd_ctrl_sel_n_o,
    output logic micro_ctrl_sel_n_o,
    output logic prog_sel0_n_o,
    output logic prog_sel1_n_o,
    output logic cpu_init_o,
    output logic rtc_addr_latch_o,
    output logic rtc_sel_n_o,
    output logic xcvr_dir_n_o,
    output logic xcvr_oe_n_o,
    output logic [7:0] dack_o
);

    // ****************************************
    // decode helpers
    // ****************************************
    function automatic logic port_hit(input logic [19:0] a, input logic [15:0] p);
        port_hit = (a[15:0] == p);
    endfunction

    function automatic logic range_hit(input logic [19:0] a, input logic [15:0] b,
                                       input logic [7:0] m);
        range_hit = (((a[15:0] ^ b) & ~{8'h00, m}) == 16'h0000);
    endfunction

    // ****************************************
    // system clock domain
    // ****************************************
    localparam int CFG_W = 64;
    logic [7:0] dreq_m, dreq_s;
    logic [2:0] sys_pin_m, sys_pin_s;
    logic cpu_reset_req_n_d;
    logic [2:0] init_cnt;
    isa_xbus_pkg::dma_state_e dma_state;
    isa_xbus_pkg::chan_t dma_chan;
    logic dack_any;
    logic [CFG_W-1:0] cfg_sys;

    // requests arrive from another domain: two flops, nothing reads the first
    always_ff @(posedge sys_clk_i) begin
        dreq_m <= dreq_i; // see RULE20
        dreq_s <= dreq_m; // see RULE23
        sys_pin_m <= {dreq_active_high_i, gate_a20_in_i, cpu_reset_req_n_i};
        sys_pin_s <= sys_pin_m;
    end

    // polarity rides the same two flops as the requests, so a flip fakes no request
    wire [7:0] req_act = sys_pin_s[2] ? dreq_s : ~dreq_s; // see RULE19
    wire req_any = |req_act;
    wire gate_s = sys_pin_s[1];
    wire cpu_reset_req_n_s = sys_pin_s[0];
    logic [2:0] next_chan;

    // fixed priority, channel 0 highest
    always_comb begin
        next_chan = 3'h0;
        for (int i = 7; i >= 0; i--) begin
            if (req_act[i]) begin
                next_chan = i[2:0];
            end
        end
    end

    // grant only a request still active when sampled; a dropped one is never acked
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            dma_state <= isa_xbus_pkg::DMA_IDLE;
            dma_chan <= 3'h0;
        end else begin
            unique case (dma_state)
                isa_xbus_pkg::DMA_IDLE: begin
                    if (req_any) begin // see RULE19
                        dma_state <= isa_xbus_pkg::DMA_GRANT;
                        dma_chan <= next_chan;
                    end
                end
                isa_xbus_pkg::DMA_GRANT: begin
                    if (dma_done_i) begin
                        dma_state <= isa_xbus_pkg::DMA_IDLE;
                    end
                end
            endcase
        end
    end

    wire grant = (dma_state == isa_xbus_pkg::DMA_GRANT);
    wire [7:0] ack_onehot = grant ? (8'h01 << dma_chan) : 8'h00;

    // acknowledge, mask and init outputs
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            dack_o <= 8'h00;
            dack_any <= 1'b0;
            addr20_mask_n_o <= 1'b1;
            cpu_reset_req_n_d <= 1'b1;
            init_cnt <= 3'h0;
            cpu_init_o <= 1'b0;
        end else begin
            dack_o <= dack_active_high_i ? ack_onehot : ~ack_onehot; // see RULE19
            dack_any <= grant;
            addr20_mask_n_o <= gate_s | quick_addr20_bit_i; // see RULE5
            cpu_reset_req_n_d <= cpu_reset_req_n_s;
            if (cpu_reset_req_n_d && !cpu_reset_req_n_s) begin
                init_cnt <= `INIT_PULSE_CLKS; // see RULE10
            end else if (init_cnt != 3'h0) begin
                init_cnt <= init_cnt - 3'h1;
            end
            cpu_init_o <= (cpu_reset_req_n_d && !cpu_reset_req_n_s) || (init_cnt > 3'h1);
        end
    end

    // quasi-static settings and the grant flag bundled for the crossing
    always_ff @(posedge sys_clk_i) begin
        cfg_sys <= {dack_any, dma_xbus_read_i, fw_low_en_i, fw_high_en_i, kbd_en_i,
                    micro_en_i, rtc_en_i, prog0_en_i, prog1_en_i, prog0_base_i,
                    prog0_mask_i, prog1_base_i, prog1_mask_i, 7'h00};
    end

    // ****************************************
    // isa clock domain
    // ****************************************
    logic [1:0] rst_sync;
    logic [CFG_W-1:0] cfg_m, cfg_s;
    logic [37:0] pin_m, pin_s;
    logic [3:0] cmd_d;
    logic [26:0] oe_adr;
    logic oe_hold;
    logic [1:0] ale_cnt;
    logic [2:0] cyc_cnt;
    logic zws_seen;
    isa_xbus_pkg::cyc_state_e cyc_state;

    // reset and settings enter this domain through two flops
    always_ff @(posedge isa_clk_i) begin
        rst_sync <= {rst_sync[0], rst_i};
        cfg_m <= cfg_sys;
        cfg_s <= cfg_m;
        pin_m <= {sa_i, la_i, ~memr_n_i, ~memw_n_i, ~ior_n_i, ~iow_n_i, dma_cycle_i,
                  pci_master_i, isa_master_i, ~io16_n_i, ~mem16_n_i, ~zerows_n_i,
                  iochrdy_i};
        pin_s <= pin_m;
    end

    wire isa_rst = rst_sync[1];
    wire [19:0] sa = pin_s[37:18];
    wire [6:0] la = pin_s[17:11];
    wire memr = pin_s[10];
    wire memw = pin_s[9];
    wire ior = pin_s[8];
    wire iow = pin_s[7];
    wire dma = pin_s[6];
    wire own = pin_s[5];
    wire isam = pin_s[4];
    wire io16 = pin_s[3];
    wire mem16 = pin_s[2];
    wire zws = pin_s[1];
    wire chrdy = pin_s[0];
    wire [3:0] cmd = {memr, memw, ior, iow};
    wire cmd_any = |cmd;
    wire [26:0] adr_now = {la, sa};
    wire dack_s = cfg_s[63];
    wire dma_xrd = cfg_s[62];
    wire fw_lo_en = cfg_s[61];
    wire fw_hi_en = cfg_s[60];
    wire kbd_en = cfg_s[59];
    wire mic_en = cfg_s[58];
    wire rtc_en = cfg_s[57];
    wire p0_en = cfg_s[56];
    wire p1_en = cfg_s[55];
    wire [15:0] p0_base = cfg_s[54:39];
    wire [7:0] p0_mask = cfg_s[38:31];
    wire [15:0] p1_base = cfg_s[30:15];
    wire [7:0] p1_mask = cfg_s[14:7];

    // address decode; la[6:3] is la[23:20]
    wire io_cyc = (ior | iow) & ~dma;
    wire mem_cyc = (memr | memw) & ~dma;
    wire below1m = (la[6:3] == 4'h0);
    wire fw_alias = (la[6:3] == `FW_LOW_ALIAS) || (la[6:3] == `FW_TOP_ALIAS);
    wire fw_seg = fw_alias && (la[2:0] == `FW_SEG_BITS);
    wire fw_dec = fw_seg && (sa[16] ? fw_hi_en : fw_lo_en);
    wire fw_hit = mem_cyc & fw_dec; // see RULE6
    wire kbd_hit = io_cyc & kbd_en & (port_hit(sa, `KBD_DATA_PORT) |
                                       port_hit(sa, `KBD_CMD_PORT)); // see RULE7
    wire mic_hit = io_cyc & mic_en & (port_hit(sa, `MICRO_DATA_PORT) |
                                       port_hit(sa, `MICRO_CMD_PORT)); // see RULE8
    wire rtc_hit = io_cyc & rtc_en & port_hit(sa, `RTC_DATA_PORT); // see RULE12
    wire p0_hit = io_cyc & own & p0_en & range_hit(sa, p0_base, p0_mask); // see RULE9
    wire p1_hit = io_cyc & own & p1_en & range_hit(sa, p1_base, p1_mask); // see RULE9
    wire xdec = fw_hit | kbd_hit | mic_hit | rtc_hit | p0_hit | p1_hit; // see RULE17
    wire ale_start = iow & ~cmd_d[0] & ~dma & port_hit(sa, `RTC_INDEX_PORT); // see RULE11

    // direction: i/o reads outside dma cycles, memory reads per master, dma reads by ack
    wire rd_pci = own & (ior | (memr & (fw_dec | apic_hit_i))); // see RULE14
    wire rd_isa = isam & (ior | (memr & fw_dec)); // see RULE15
    wire rd_dma = dack_s & dma_xrd; // see RULE16
    wire dir_low = (ior & ~dma) | rd_pci | rd_isa | rd_dma; // see RULE13

    // output enable: pci follows command, isa master holds until address moves
    wire oe_pci = own & cmd_any & xdec; // see RULE18
    wire oe_start = isam & cmd_any & xdec;
    wire adr_moved = (adr_now != oe_adr);

    always_ff @(posedge isa_clk_i) begin
        if (isa_rst) begin
            oe_hold <= 1'b0;
            oe_adr <= 27'h0000000;
        end else if (oe_start) begin
            oe_hold <= 1'b1;
            oe_adr <= adr_now;
        end else if (adr_moved) begin
            oe_hold <= 1'b0; // see RULE18
        end
    end

    // cycle length: zero wait only with ready high, never on 16-bit i/o
    wire io16_cyc = (ior | iow) & io16;
    wire mem16_cyc = (memr | memw) & mem16;
    wire [2:0] zws_len = mem16_cyc ? `ZWS_MEM16_CLKS : `ZWS_8BIT_CLKS; // see RULE2
    wire zws_take = zws & chrdy & ~io16_cyc & (cyc_cnt < zws_len); // see RULE3 see RULE4
    wire zws_on = zws_seen | zws_take;
    wire [2:0] std_len = io16_cyc ? `STD_IO16_CLKS :
                         (mem16_cyc ? `STD_MEM16_CLKS : `STD_8BIT_CLKS);
    wire [2:0] cyc_len = zws_on ? zws_len : std_len;
    wire cyc_fin = (cyc_state == isa_xbus_pkg::CYC_RUN) && chrdy &&
                   (cyc_cnt >= cyc_len - 3'h1); // see RULE4

    // cycle counter, started by the command's leading edge
    always_ff @(posedge isa_clk_i) begin
        if (isa_rst) begin
            cyc_state <= isa_xbus_pkg::CYC_IDLE;
            cyc_cnt <= 3'h0;
            zws_seen <= 1'b0;
        end else begin
            unique case (cyc_state)
                isa_xbus_pkg::CYC_IDLE: begin
                    cyc_cnt <= 3'h1;
                    zws_seen <= 1'b0;
                    if (cmd_any && cmd_d == 4'h0) begin
                        cyc_state <= isa_xbus_pkg::CYC_RUN;
                    end
                end
                isa_xbus_pkg::CYC_RUN: begin
                    zws_seen <= zws_on;
                    if (cyc_fin || !cmd_any) begin
                        cyc_state <= isa_xbus_pkg::CYC_IDLE;
                    end else if (cyc_cnt != 3'h7) begin
                        cyc_cnt <= cyc_cnt + 3'h1;
                    end
                end
            endcase
        end
    end

    // registered pin drivers with general-purpose takeover
    always_ff @(posedge isa_clk_i) begin
        if (isa_rst) begin
            cmd_d <= 4'h0;
            ale_cnt <= 2'h0;
            smemw_n_o <= 1'b1;
            cycle_end_o <= 1'b0;
            firmware_sel_n_o <= 1'b1;
            kbd_ctrl_sel_n_o <= 1'b1;
            micro_ctrl_sel_n_o <= 1'b1;
            prog_sel0_n_o <= 1'b1;
            prog_sel1_n_o <= 1'b1;
            rtc_addr_latch_o <= 1'b0;
            rtc_sel_n_o <= 1'b1;
            xcvr_dir_n_o <= 1'b1;
            xcvr_oe_n_o <= 1'b1;
        end else begin
            cmd_d <= cmd;
            if (ale_start) begin
                ale_cnt <= `RTC_ALE_CLKS; // see RULE11
            end else if (ale_cnt != 2'h0) begin
                ale_cnt <= ale_cnt - 2'h1;
            end
            smemw_n_o <= ~(memw & below1m & (dma | own | isam)); // see RULE1
            cycle_end_o <= cyc_fin;
            firmware_sel_n_o <= ~fw_hit;
            micro_ctrl_sel_n_o <= ~mic_hit;
            prog_sel0_n_o <= ~p0_hit;
            prog_sel1_n_o <= ~p1_hit;
            // general-purpose values replace unused controls
            kbd_ctrl_sel_n_o <= kbd_gpo_mode_i ? gp_out_kbdsel_alt_i : ~kbd_hit; // see RULE22
            rtc_sel_n_o <= rtc_gpo_mode_i ? gp_out_rtcsel_alt_i : ~rtc_hit;
            rtc_addr_latch_o <= rtc_gpo_mode_i ? gp_out_rtc_addr_latch_alt_i :
                                (ale_start || ale_cnt > 2'h1);
            xcvr_dir_n_o <= xbus_gpo_mode_i ? gp_out_dir_alt_i : ~dir_low;
            xcvr_oe_n_o <= xbus_gpo_mode_i ? gp_out_oe_alt_i :
                           ~(oe_pci | oe_start | (oe_hold & ~adr_moved));
        end
    end

    // ****************************************
    // checks
    // ****************************************
    sequence s_ale_two;
        rtc_addr_latch_o ##1 rtc_addr_latch_o ##1 !rtc_addr_latch_o;
    endsequence

    a_rtc_ale_len: assert property (@(posedge isa_clk_i) disable iff (isa_rst) // see RULE11
        (ale_start && !rtc_gpo_mode_i && ale_cnt == 2'h0) |=> s_ale_two)
        else $error("rtc latch not two clocks");
    a_smemw_above: assert property (@(posedge isa_clk_i) disable iff (isa_rst) // see RULE1
        !below1m |=> smemw_n_o)
        else $error("standard write above first megabyte");
    a_fw_no_dma: assert property (@(posedge isa_clk_i) disable iff (isa_rst) // see RULE6
        dma |=> firmware_sel_n_o)
        else $error("firmware select during dma");
    a_kbd_port_sel: assert property (@(posedge isa_clk_i) disable iff (isa_rst) // see RULE7
        (io_cyc && kbd_en && port_hit(sa, `KBD_CMD_PORT) && !kbd_gpo_mode_i)
        |=> !kbd_ctrl_sel_n_o)
        else $error("keyboard select missing");
    a_dir_io_read: assert property (@(posedge isa_clk_i) disable iff (isa_rst) // see RULE13
        (ior && !dma && !xbus_gpo_mode_i) |=> !xcvr_dir_n_o)
        else $error("direction high on io read");
    a_oe_disabled: assert property (@(posedge isa_clk_i) disable iff (isa_rst) // see RULE17
        (!xdec && !oe_hold && !xbus_gpo_mode_i) |=> xcvr_oe_n_o)
        else $error("output enable without decode");
    a_io16_normal: assert property (@(posedge isa_clk_i) disable iff (isa_rst) // see RULE3
        (cyc_fin && io16_cyc) |-> cyc_cnt >= `STD_IO16_CLKS - 3'h1)
        else $error("16-bit io cycle shortened");
    a_zws_mem16: assert property (@(posedge isa_clk_i) disable iff (isa_rst) // see RULE2
        (cyc_fin && zws_on && mem16_cyc) |-> cyc_cnt == `ZWS_MEM16_CLKS - 3'h1)
        else $error("zero wait 16-bit length wrong");
    a_a20_mask: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see RULE5
        (!gate_s && !quick_addr20_bit_i) |=> !addr20_mask_n_o)
        else $error("address-20 mask not asserted");
    a_no_idle_grant: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see RULE19
        (!grant && !req_any) |=> !grant)
        else $error("grant without request");
    a_init_from_cpu_reset_req_n: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see RULE10
        (cpu_reset_req_n_d && !cpu_reset_req_n_s) |=> cpu_init_o ##1 cpu_init_o)
        else $error("init pulse missing");

endmodule

/* tb/isa_xbus_partner.sv */
`timescale 1ns/1ps
// ****************************************
// far side: dma requesters and one isa slave
// ****************************************
module isa_xbus_partner (
    input wire logic sys_clk_i,
    input wire logic isa_clk_i,
    input wire logic rst_i,
    input wire logic [7:0] req_mask_i,
    input wire logic [7:0] glitch_i,
    input wire logic dreq_active_high_i,
    input wire logic dack_active_high_i,
    input wire logic [7:0] dack_i,
    input wire logic cmd_active_i,
    input wire logic zws_en_i,
    input wire logic wide_i,
    input wire logic [3:0] wait_clks_i,
    output logic [7:0] dreq_o,
    output logic zerows_n_o,
    output logic iochrdy_o,
    output logic io16_n_o,
    output logic mem16_n_o
);
    logic [7:0] pend;
    logic [3:0] wait_left;
    logic cmd_q;
    wire [7:0] dack_on = dack_active_high_i ? dack_i : ~dack_i;
    wire [7:0] act = pend | glitch_i;
    wire first = cmd_active_i & ~cmd_q & (wait_clks_i != 4'h0);
    // a request stays up until its acknowledge shows
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            pend <= 8'h00;
        end else begin
            pend <= (pend | req_mask_i) & ~dack_on;
        end
    end
    // glitch bits are pulses too short for any clock edge to catch
    assign dreq_o = dreq_active_high_i ? act : ~act;
    // ready held low for a set number of clocks from the command
    always_ff @(posedge isa_clk_i) begin
        if (rst_i) begin
            cmd_q <= 1'b0;
            wait_left <= 4'h0;
        end else begin
            cmd_q <= cmd_active_i;
            if (first) begin
                wait_left <= wait_clks_i;
            end else if (wait_left != 4'h0) begin
                wait_left <= wait_left - 4'h1;
            end
        end
    end
    // zero wait claimed only while a command runs, even during waits
    assign iochrdy_o = (wait_left == 4'h0) & ~first;
    assign zerows_n_o = ~(zws_en_i & cmd_active_i);
    assign io16_n_o = ~wide_i;
    assign mem16_n_o = ~wide_i;
endmodule

/* tb/tb_isa_xbus_select_control.sv */
`timescale 1ns/1ps
`include "isa_xbus_params.svh"
module tb_isa_xbus_select_control;
// ****************************************
// pins, named as the ports so the instance binds by name
// ****************************************
logic sys_clk_i = 0, isa_clk_i = 0, rst_i = 1;
logic [19:0] sa_i = 0;
logic [6:0] la_i = 0;
logic memr_n_i = 1, memw_n_i = 1, ior_n_i = 1, iow_n_i = 1;
logic dma_cycle_i = 0, pci_master_i = 0, isa_master_i = 0, apic_hit_i = 0;
logic io16_n_i, mem16_n_i, zerows_n_i, iochrdy_i;
logic [7:0] dreq_i, dack_o;
logic gate_a20_in_i = 1, cpu_reset_req_n_i = 1, dma_done_i = 0, dma_xbus_read_i = 1;
logic dreq_active_high_i = 1, dack_active_high_i = 1, quick_addr20_bit_i = 0;
logic fw_low_en_i = 1, fw_high_en_i = 1, kbd_en_i = 1, micro_en_i = 1, rtc_en_i = 1;
logic prog0_en_i = 1, prog1_en_i = 1;
logic [15:0] prog0_base_i = 16'h0300, prog1_base_i = 16'h0310;
logic [7:0] prog0_mask_i = 8'h07, prog1_mask_i = 8'h00;
logic xbus_gpo_mode_i = 0, kbd_gpo_mode_i = 0, rtc_gpo_mode_i = 0;
logic gp_out_dir_alt_i = 0, gp_out_oe_alt_i = 0, gp_out_rtcsel_alt_i = 0;
logic gp_out_rtc_addr_latch_alt_i = 0, gp_out_kbdsel_alt_i = 0;
logic smemw_n_o, cycle_end_o, addr20_mask_n_o, firmware_sel_n_o, kbd_ctrl_sel_n_o;
logic micro_ctrl_sel_n_o, prog_sel0_n_o, prog_sel1_n_o, cpu_init_o, rtc_addr_latch_o;
logic rtc_sel_n_o, xcvr_dir_n_o, xcvr_oe_n_o;
logic [7:0] req_mask = 0, glitch = 0;
logic cmd_act = 0, zws = 0, wide = 0;
logic [3:0] wait_clks = 0;
int fail_count = 0, num_checks = 0, base = -1, n = 0;
// acknowledge in active-high form, and the select group as one vector
wire [7:0] dack_act = dack_o ^ {8{~dack_active_high_i}};
wire [8:0] snap_w = {firmware_sel_n_o, kbd_ctrl_sel_n_o, micro_ctrl_sel_n_o, prog_sel0_n_o,
    prog_sel1_n_o, rtc_sel_n_o, xcvr_dir_n_o, xcvr_oe_n_o, smemw_n_o};
// link clock period 125 ns, rising edges never coincide with the system clock
always #25 sys_clk_i = ~sys_clk_i;
always #62.5 isa_clk_i = ~isa_clk_i;
isa_xbus_select_control i_dut (.*);
isa_xbus_partner i_far (.sys_clk_i(sys_clk_i), .isa_clk_i(isa_clk_i), .rst_i(rst_i),
    .req_mask_i(req_mask), .glitch_i(glitch), .dreq_active_high_i(dreq_active_high_i),
    .dack_active_high_i(dack_active_high_i), .dack_i(dack_o), .cmd_active_i(cmd_act),
    .zws_en_i(zws), .wide_i(wide), .wait_clks_i(wait_clks), .dreq_o(dreq_i),
    .zerows_n_o(zerows_n_i), .iochrdy_o(iochrdy_i), .io16_n_o(io16_n_i), .mem16_n_o(mem16_n_i));
// ****************************************
// tasks
// ****************************************
task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
        fail_count++;
        $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
endtask
task report_and_stop;
    $display("checks=%0d mismatches=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
        $display("Test passed");
    else
        $display("Test failed");
    $finish;
endtask
task automatic cfg(input logic z, input logic w, input logic [3:0] c);
    {zws, wide, wait_clks} = {z, w, c};
endtask
// one bus cycle: who 0 pci master, 1 isa master, 2 dma; kind 0 ior 1 iow 2 memr 3 memw
task automatic cyc(input logic [19:0] a, input logic [6:0] l, input logic [1:0] kind,
    input logic [1:0] who, input logic apic, input int len, input logic [8:0] exp,
    input logic [8:0] msk);
    int endat;
    int ale;
    logic [8:0] snap;
    endat = 0;
    ale = 0;
    snap = 9'h1FF;
    @(posedge isa_clk_i) #2;
    {sa_i, la_i, apic_hit_i} = {a, l, apic};
    {pci_master_i, isa_master_i, dma_cycle_i} = 3'h4 >> who;
    repeat (2) @(posedge isa_clk_i) #2;
    {ior_n_i, iow_n_i, memr_n_i, memw_n_i} = ~(4'h8 >> kind);
    cmd_act = 1;
    for (int i = 1; i <= 14; i++) begin
        @(posedge isa_clk_i) #2;
        if (cycle_end_o === 1'b1 && endat == 0) endat = i;
        ale += int'(rtc_addr_latch_o);
        if (i == 8) snap = snap_w;
    end
    {ior_n_i, iow_n_i, memr_n_i, memw_n_i} = 4'hF;
    cmd_act = 0;
    sa_i = 20'h00000;
    repeat (5) @(posedge isa_clk_i) #2;
    check(snap | msk, exp | msk);
    check(ale, (kind == 2'h1 && a == 20'h00070) ? 2 : 0);
    check({xcvr_dir_n_o, xcvr_oe_n_o}, 2'h3);
    if (len > 0) begin
        if (base < 0) base = endat - len;
        check(endat - len, base);
    end
    if (len < 0) check(endat - base > `ZWS_8BIT_CLKS, 1);
endtask
// wait for exactly this grant vector, bounded
task automatic wait_ack(input logic [7:0] exp);
    for (int i = 0; i < 20 && dack_act !== exp; i++) @(posedge sys_clk_i) #2;
    #2 check(dack_act, exp);
endtask
task automatic dma_run(input logic rh, input logic ah);
    @(posedge sys_clk_i) #2;
    {dreq_active_high_i, dack_active_high_i} = {rh, ah};
    repeat (4) @(posedge sys_clk_i) #2;
    req_mask = 8'h22;
    @(posedge sys_clk_i) #2;
    req_mask = 8'h00;
    for (int k = 0; k < 2; k++) begin
        wait_ack(k ? 8'h20 : 8'h02);
        repeat (4) @(posedge isa_clk_i);
        repeat (6) @(posedge isa_clk_i) #2 check(xcvr_dir_n_o, 0);
        @(posedge sys_clk_i) #2 dma_done_i = 1;
        @(posedge sys_clk_i) #2 dma_done_i = 0;
    end
    repeat (4) @(posedge isa_clk_i);
    repeat (6) @(posedge isa_clk_i) #2 check({dack_act, xcvr_dir_n_o}, 9'h001);
    @(posedge sys_clk_i) #2 glitch = 8'h08;
    #20 glitch = 8'h00;
    repeat (10) @(posedge sys_clk_i) #2 check(dack_act, 8'h00);
endtask
// ****************************************
// main sequence and watchdog
// ****************************************
initial begin
    #500000 fail_count++;
    report_and_stop;
end
initial begin
    repeat (5) @(posedge isa_clk_i) #2;
    rst_i = 0;
    repeat (6) @(posedge isa_clk_i) #2;
    check(snap_w, 9'h1FF);
    cyc(20'h00080, 0, 0, 0, 0, `STD_8BIT_CLKS, 9'h1FB, 0);
    cfg(1, 0, 0); cyc(20'h00080, 0, 0, 0, 0, `ZWS_8BIT_CLKS, 9'h1FB, 0);
    cfg(1, 1, 0); cyc(20'h00080, 0, 0, 0, 0, `STD_IO16_CLKS, 9'h1FB, 0);
    cyc(20'h10000, 0, 2, 0, 0, `ZWS_MEM16_CLKS, 9'h1FF, 0);
    cfg(0, 1, 0); cyc(20'h10000, 0, 2, 0, 1, `STD_MEM16_CLKS, 9'h1FB, 9'h002);
    cfg(1, 0, 4); cyc(20'h00080, 0, 0, 0, 0, -1, 9'h1FB, 0);
    cfg(0, 0, 0); cyc(20'h10000, 0, 2, 1, 1, 0, 9'h1FF, 9'h002);
    cyc(20'h00060, 0, 0, 0, 0, 0, 9'h179, 0);
    cyc(20'h00064, 0, 1, 0, 0, 0, 9'h17D, 0);
    cyc(20'h00062, 0, 0, 0, 0, 0, 9'h1B9, 0);
    cyc(20'h00066, 0, 1, 0, 0, 0, 9'h1BD, 0);
    cyc(20'h00070, 0, 1, 0, 0, 0, 9'h1FF, 9'h1FF);
    cyc(20'h00071, 0, 0, 0, 0, 0, 9'h1F1, 0);
    cyc(20'h00304, 0, 0, 0, 0, 0, 9'h1D9, 0);
    cyc(20'h00310, 0, 0, 0, 0, 0, 9'h1E9, 0);
    cyc(20'h00304, 0, 0, 1, 0, 0, 9'h1FB, 9'h002);
    cyc(20'h00060, 0, 0, 2, 0, 0, 9'h1FF, 9'h002);
    cyc(20'hF0000, 7, 2, 0, 0, 0, 9'h0F9, 0);
    cyc(20'hF0000, 7, 2, 1, 0, 0, 9'h0F9, 0);
    cyc(20'hF0000, 7, 2, 2, 0, 0, 9'h1FF, 9'h006);
    cyc(20'h20000, 1, 3, 0, 0, 0, 9'h1FE, 0);
    cyc(20'h20000, 9, 3, 0, 0, 0, 9'h1FF, 0);
    cyc(20'h20000, 1, 3, 1, 0, 0, 9'h1FE, 0);
    kbd_en_i = 0; cyc(20'h00060, 0, 0, 0, 0, 0, 9'h1FB, 9'h080);
    {kbd_en_i, xbus_gpo_mode_i, kbd_gpo_mode_i, rtc_gpo_mode_i} = 4'hF;
    for (int v = 0; v < 2; v++) begin
        {gp_out_dir_alt_i, gp_out_oe_alt_i, gp_out_rtcsel_alt_i, gp_out_rtc_addr_latch_alt_i,
            gp_out_kbdsel_alt_i} = v ? 5'h15 : 5'h0A;
        repeat (5) @(posedge isa_clk_i) #2;
        check({xcvr_dir_n_o, xcvr_oe_n_o, rtc_sel_n_o, rtc_addr_latch_o, kbd_ctrl_sel_n_o},
            v ? 5'h15 : 5'h0A);
    end
    {xbus_gpo_mode_i, kbd_gpo_mode_i, rtc_gpo_mode_i} = 3'h0;
    for (int g = 0; g < 4; g++) begin
        @(posedge sys_clk_i) #2 {gate_a20_in_i, quick_addr20_bit_i} = g[1:0];
        repeat (5) @(posedge sys_clk_i) #2;
        check(addr20_mask_n_o, g != 0);
    end
    @(posedge sys_clk_i) #2 cpu_reset_req_n_i = 0;
    for (int i = 0; i < 20; i++) begin
        @(posedge sys_clk_i) #2 n += int'(cpu_init_o);
        if (i == 3) cpu_reset_req_n_i = 1;
    end
    check(n, `INIT_PULSE_CLKS);
    dma_run(1, 1);
    dma_run(0, 0);
    report_and_stop;
end
endmodule
